// *** include/ctr_consts.svh ***
`ifndef CTR_CONSTS_SVH
`define CTR_CONSTS_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define CTR_IDX_COLL      6'h1C
`define CTR_IDX_TXH       6'h1D
`define CTR_IDX_TXL       6'h1E
`define CTR_IDX_RATE      6'h1F
`define CTR_IDX_ADC       6'h20
`define CTR_IDX_ISTAT     6'h30
`define CTR_IDX_IMASK     6'h31
`define CTR_IDX_CTRL      6'h32

// ==========================================
// field positions
`define CTR_COLL_BYTE_LSB 4
`define CTR_COLL_BIT_LSB  1
`define CTR_COLL_PAR_BIT  0
`define CTR_TXL_CNT_LSB   3
`define CTR_RATE_LSB      4
`define CTR_IRQ_PAR       0
`define CTR_IRQ_COLL      1
`define CTR_IRQ_RATE      2
`define CTR_IRQ_ADC       3
`define CTR_CTRL_ANCTL    0

// ==========================================
// reset values and limits
`define CTR_RST_BYTE      8'h00
`define CTR_RST_IRQ       4'h0
`define CTR_ANTICOL_MAXB  13'h0006

`endif

// *** include/ctr_pkg.sv ***
package ctr_pkg;

  typedef enum logic [1:0] {
    CTR_CAP_WAIT = 2'b01,
    CTR_CAP_HELD = 2'b10
  } ctr_cap_state_t;

  typedef struct packed {
    ctr_cap_state_t st;
    logic [7:0]     value;
    logic           captured;
  } ctr_cap_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  tx_hi;
    logic [7:0]  tx_lo;
    logic [7:0]  rate;
    logic [7:0]  adc;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic        anctl;
    logic        nopar;
    logic        irq;
  } ctr_regs_t;

endpackage

// *** include/ctr_coll_if.sv ***
`timescale 1ns/1ps
interface ctr_coll_if;
  logic        clr;
  logic        rx_start;
  logic        coll;
  logic [12:0] nbytes;
  logic [2:0]  nbit;
  logic        par;
  logic [7:0]  value;
  logic        captured;

  modport cap (
    input  clr,
    input  rx_start,
    input  coll,
    input  nbytes,
    input  nbit,
    input  par,
    output value,
    output captured
  );
  modport host (
    output clr,
    output rx_start,
    output coll,
    output nbytes,
    output nbit,
    output par,
    input  value,
    input  captured
  );
endinterface

// *** src/ctr_coll_capture.sv ***
`timescale 1ns/1ps
`include "ctr_consts.svh"

module ctr_coll_capture (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // collision events
  ctr_coll_if.cap  cif
);

  ctr_pkg::ctr_cap_t r;
  ctr_pkg::ctr_cap_t next_r;
  logic              in_range;

  assign cif.value    = r.value;
  assign cif.captured = r.captured;

  // ==========================================
  // capture logic
  always_comb begin
    next_r          = r;
    next_r.captured = 1'b0;
    in_range = cif.nbytes <= `CTR_ANTICOL_MAXB;
    case (r.st)
      ctr_pkg::CTR_CAP_WAIT: begin
        if (cif.coll && in_range) begin
          next_r.value[7:`CTR_COLL_BYTE_LSB] = cif.nbytes[3:0];
          next_r.value[3:`CTR_COLL_BIT_LSB]  = cif.nbit;
          next_r.value[`CTR_COLL_PAR_BIT]    = cif.par;
          next_r.captured = 1'b1;
          next_r.st       = ctr_pkg::CTR_CAP_HELD;
        end
      end
      ctr_pkg::CTR_CAP_HELD: begin
        next_r.st = ctr_pkg::CTR_CAP_HELD;
      end
      default: begin
        next_r.st = ctr_pkg::CTR_CAP_WAIT;
      end
    endcase
    if (cif.rx_start) begin
      next_r.st       = ctr_pkg::CTR_CAP_WAIT;
      next_r.value    = `CTR_RST_BYTE;
      next_r.captured = 1'b0;
    end
    if (cif.clr) begin
      next_r.st       = ctr_pkg::CTR_CAP_WAIT;
      next_r.value    = `CTR_RST_BYTE;
      next_r.captured = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.st       <= ctr_pkg::CTR_CAP_WAIT;
      r.value    <= `CTR_RST_BYTE;
      r.captured <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_cap_pos;
    (r.st == ctr_pkg::CTR_CAP_WAIT) && cif.coll && in_range && !cif.rx_start && !cif.clr
      |=> (cif.value == {$past(cif.nbytes[3:0]), $past(cif.nbit), $past(cif.par)})
          && cif.captured;
  endproperty
  a_cap_pos: assert property (p_cap_pos) else $error("collision position wrong");

  property p_cap_long;
    cif.coll && !in_range && !cif.rx_start && !cif.clr |=> $stable(cif.value) && !cif.captured;
  endproperty
  a_cap_long: assert property (p_cap_long) else $error("long frame changed display");

  property p_cap_first;
    (r.st == ctr_pkg::CTR_CAP_HELD) && !cif.rx_start && !cif.clr
      |=> $stable(cif.value)[*2] or cif.rx_start or cif.clr;
  endproperty
  a_cap_first: assert property (p_cap_first) else $error("later collision overwrote");

  c_cap_long: cover property (cif.coll && !in_range);

endmodule

// *** src/ctr_regs.sv ***
`timescale 1ns/1ps
`include "ctr_consts.svh"

// Function
// - a captured collision shows the count of full bytes before it in bits 7..4.
// - a captured collision shows its bit position within the byte in bits 3..1.
// - bit 0 flags a collision on a parity bit, raised as error only for the first one.
// - collisions in frames longer than an anticollision command leave the display alone.
// - display, bit-rate and converter registers are read-only and cleared by reset or default.
// - a writable 13-bit byte count splits into eight high bits and five low bits 7..3.
// - bits 2..0 of the low count register give split-byte bits, zero meaning none.
// - with a split byte in anticollision mode, the frame goes out without parity.
// - both count registers clear to zero on reset and on the default command.
// - wake-up with anticollision set, card idle and nonzero split bits raises parity error.
// - detected bit rate is held in bits 7..4 with bits 3..0 unused.
// - the converter register shows the last completed eight-bit result.
// - reading the interrupt status clears it; an event set on the edge that latches the read data is cleared unreported.
module ctr_regs (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // device events
  input  wire logic        set_default_i,
  input  wire logic        rx_start_i,
  input  wire logic        coll_i,
  input  wire logic [12:0] coll_bytes_i,
  input  wire logic [2:0]  coll_bit_i,
  input  wire logic        coll_par_i,
  input  wire logic        wupa_cmd_i,
  input  wire logic        card_idle_i,
  input  wire logic        rate_valid_i,
  input  wire logic [3:0]  rate_i,
  input  wire logic        adc_done_i,
  input  wire logic [7:0]  adc_i,
  // transmit setup
  output logic      [12:0] tx_count_o,
  output logic      [2:0]  split_bits_o,
  output logic             tx_no_parity_o,
  // interrupt
  output logic             irq_o
);

  ctr_pkg::ctr_regs_t r;
  ctr_pkg::ctr_regs_t next_r;

  ctr_coll_if cif ();

  logic       req;
  logic [5:0] idx;
  logic       wr;
  logic       rd;
  logic [3:0] ev;
  logic [3:0] clr;

  // ==========================================
  // helpers
  function automatic logic [31:0] widen(input logic [7:0] b);
    widen = {24'h000000, b};
  endfunction

  function automatic logic split_on(input logic a, input logic [7:0] lo);
    split_on = a && (lo[2:0] != 3'h0);
  endfunction

  // ==========================================
  // collision capture
  assign cif.clr      = set_default_i;
  assign cif.rx_start = rx_start_i;
  assign cif.coll     = coll_i;
  assign cif.nbytes   = coll_bytes_i;
  assign cif.nbit     = coll_bit_i;
  assign cif.par      = coll_par_i;

  ctr_coll_capture u_cap (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif.cap)
  );

  // ==========================================
  // bus decode
  // the access completes on the edge where ack is already high, so a
  // write or a read-clear lands exactly when the master takes the answer
  assign req = cyc_i && stb_i;
  assign idx = adr_i[7:2];
  assign wr  = req && r.ack && we_i && sel_i[0];
  assign rd  = req && r.ack && !we_i;

  // ==========================================
  // next state
  always_comb begin
    next_r     = r;
    next_r.ack = req && !r.ack;
    ev         = `CTR_RST_IRQ;
    clr        = `CTR_RST_IRQ;

    if (req && !r.ack) begin
      if (we_i) begin
        next_r.rdata = 32'h00000000;
      end else begin
        case (idx)
          `CTR_IDX_COLL:  next_r.rdata = widen(cif.value);
          `CTR_IDX_TXH:   next_r.rdata = widen(r.tx_hi);
          `CTR_IDX_TXL:   next_r.rdata = widen(r.tx_lo);
          `CTR_IDX_RATE:  next_r.rdata = widen(r.rate);
          `CTR_IDX_ADC:   next_r.rdata = widen(r.adc);
          `CTR_IDX_ISTAT: next_r.rdata = {28'h0000000, r.stat};
          `CTR_IDX_IMASK: next_r.rdata = {28'h0000000, r.mask};
          `CTR_IDX_CTRL:  next_r.rdata = {31'h00000000, r.anctl};
          default:        next_r.rdata = 32'h00000000;
        endcase
      end
    end

    if (wr && idx == `CTR_IDX_TXH) begin
      next_r.tx_hi = dat_i[7:0];
    end
    if (wr && idx == `CTR_IDX_TXL) begin
      next_r.tx_lo = dat_i[7:0];
    end
    if (wr && idx == `CTR_IDX_IMASK) begin
      next_r.mask = dat_i[3:0];
    end
    if (wr && idx == `CTR_IDX_CTRL) begin
      next_r.anctl = dat_i[`CTR_CTRL_ANCTL];
    end
    // write one to clear status
    if (wr && idx == `CTR_IDX_ISTAT) begin
      clr = dat_i[3:0];
    end
    if (rd && idx == `CTR_IDX_ISTAT) begin
      clr = 4'hF;
    end

    if (rate_valid_i) begin
      next_r.rate = {rate_i, 4'h0};
      ev[`CTR_IRQ_RATE] = 1'b1;
    end
    if (adc_done_i) begin
      next_r.adc = adc_i;
      ev[`CTR_IRQ_ADC] = 1'b1;
    end
    if (cif.captured) begin
      ev[`CTR_IRQ_COLL] = 1'b1;
      ev[`CTR_IRQ_PAR]  = cif.value[`CTR_COLL_PAR_BIT];
    end
    if (wupa_cmd_i && card_idle_i && split_on(r.anctl, r.tx_lo)) begin
      ev[`CTR_IRQ_PAR] = 1'b1;
    end
    // a new event wins over a clear in the same cycle
    next_r.stat = (r.stat & ~clr) | ev;

    if (set_default_i) begin
      next_r.tx_hi = `CTR_RST_BYTE;
      next_r.tx_lo = `CTR_RST_BYTE;
      next_r.rate  = `CTR_RST_BYTE;
      next_r.adc   = `CTR_RST_BYTE;
      next_r.stat  = `CTR_RST_IRQ;
      next_r.mask  = `CTR_RST_IRQ;
      next_r.anctl = 1'b0;
    end

    next_r.nopar = split_on(next_r.anctl, next_r.tx_lo);
    next_r.irq   = |(next_r.stat & next_r.mask);
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.ack   <= 1'b0;
      r.rdata <= 32'h00000000;
      r.tx_hi <= `CTR_RST_BYTE;
      r.tx_lo <= `CTR_RST_BYTE;
      r.rate  <= `CTR_RST_BYTE;
      r.adc   <= `CTR_RST_BYTE;
      r.stat  <= `CTR_RST_IRQ;
      r.mask  <= `CTR_RST_IRQ;
      r.anctl <= 1'b0;
      r.nopar <= 1'b0;
      r.irq   <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // outputs
  assign dat_o          = r.rdata;
  assign ack_o          = r.ack;
  assign tx_count_o     = {r.tx_hi, r.tx_lo[7:`CTR_TXL_CNT_LSB]};
  assign split_bits_o   = r.tx_lo[2:0];
  assign tx_no_parity_o = r.nopar;
  assign irq_o          = r.irq;

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_txh;
    wr && idx == `CTR_IDX_TXH && !set_default_i
      |=> tx_count_o[12:5] == $past(dat_i[7:0]);
  endproperty
  a_txh: assert property (p_txh) else $error("count high not written");

  property p_txl;
    wr && idx == `CTR_IDX_TXL && !set_default_i
      |=> {tx_count_o[4:0], split_bits_o} == $past(dat_i[7:0]);
  endproperty
  a_txl: assert property (p_txl) else $error("count low or split not written");

  property p_nopar;
    ##1 tx_no_parity_o == (r.anctl && split_bits_o != 3'h0);
  endproperty
  a_nopar: assert property (p_nopar) else $error("parity suppression wrong");

  property p_wupa;
    wupa_cmd_i && card_idle_i && r.anctl && split_bits_o != 3'h0 && !set_default_i
      |=> r.stat[`CTR_IRQ_PAR];
  endproperty
  a_wupa: assert property (p_wupa) else $error("wake-up parity error missing");

  property p_rdclr;
    rd && idx == `CTR_IDX_ISTAT && ev == 4'h0 |=> r.stat == 4'h0;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("status not cleared by read");

  property p_default;
    set_default_i |=> tx_count_o == 13'h0000 && split_bits_o == 3'h0
                      && r.rate == 8'h00 && r.adc == 8'h00 && cif.value == 8'h00
                      && r.stat == 4'h0 && r.mask == 4'h0;
  endproperty
  a_default: assert property (p_default) else $error("default did not clear");

  property p_rate;
    rate_valid_i && !set_default_i |=> r.rate == {$past(rate_i), 4'h0};
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate not stored");

  property p_adc;
    adc_done_i && !set_default_i |=> r.adc == $past(adc_i) ##1 1'b1;
  endproperty
  a_adc: assert property (p_adc) else $error("conversion not stored");

  property p_ack;
    req && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");

  property p_irq;
    ##1 irq_o == |(r.stat & r.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt line wrong");

  // ==========================================
  // register and status behaviour
  property p_ro_coll;
    wr && idx == `CTR_IDX_COLL && !rx_start_i && !coll_i && !set_default_i
      |=> $stable(cif.value);
  endproperty
  a_ro_coll: assert property (p_ro_coll) else $error("display took a write");

  property p_ro_rate;
    wr && idx == `CTR_IDX_RATE && !rate_valid_i && !set_default_i
      |=> $stable(r.rate);
  endproperty
  a_ro_rate: assert property (p_ro_rate) else $error("bit rate register took a write");

  property p_ro_adc;
    wr && idx == `CTR_IDX_ADC && !adc_done_i && !set_default_i
      |=> $stable(r.adc);
  endproperty
  a_ro_adc: assert property (p_ro_adc) else $error("converter register took a write");

  property p_stat_set;
    (ev != 4'h0) && !set_default_i
      |=> (r.stat & $past(ev)) == $past(ev);
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status event lost");

  property p_w1c;
    wr && idx == `CTR_IDX_ISTAT && ev == 4'h0 && !set_default_i
      |=> r.stat == ($past(r.stat) & ~$past(dat_i[3:0]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("status write-one-clear wrong");

  property p_coll_ev;
    cif.captured && !set_default_i
      |=> r.stat[`CTR_IRQ_COLL];
  endproperty
  a_coll_ev: assert property (p_coll_ev) else $error("collision status missing");

  property p_par_ev;
    cif.captured && cif.value[`CTR_COLL_PAR_BIT] && !set_default_i
      |=> r.stat[`CTR_IRQ_PAR];
  endproperty
  a_par_ev: assert property (p_par_ev) else $error("parity collision error missing");

  property p_anctl;
    wr && idx == `CTR_IDX_CTRL && !set_default_i
      |=> r.anctl == $past(dat_i[`CTR_CTRL_ANCTL]);
  endproperty
  a_anctl: assert property (p_anctl) else $error("anticollision bit not written");

  property p_ack_idle;
    !req
      |=> !ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

  property p_rdata_hi;
    ack_o
      |-> dat_o[31:8] == 24'h000000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits not zero");

  c_wr_txl:  cover property (wr && idx == `CTR_IDX_TXL);
  c_rd_stat: cover property (rd && idx == `CTR_IDX_ISTAT && r.stat != 4'h0);
  c_par_irq: cover property (cif.captured && cif.value[0]);
  c_nopar:   cover property (tx_no_parity_o);

endmodule

// *** test/ctr_host_model.sv ***
`timescale 1ns/1ps
// ==========================================
// host side wishbone master
module ctr_host_model (
  // clock
  input  wire logic        clk_i,
  // wishbone answer
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // wishbone request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // count fits 13 bits
  // every count written comes from an 8-bit lane, so 8191 is never exceeded
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    // no cycle limit here: only the bench timeout may end a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule

// *** test/collision_txcount_status_regs_tb_top.sv ***
`timescale 1ns/1ps
module collision_txcount_status_regs_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic        set_default_i = 1'b0, rx_start_i = 1'b0, coll_i = 1'b0;
  logic [12:0] coll_bytes_i = 13'h0000;
  logic [2:0]  coll_bit_i = 3'h0;
  logic        coll_par_i = 1'b0, wupa_cmd_i = 1'b0, card_idle_i = 1'b0;
  logic        rate_valid_i = 1'b0, adc_done_i = 1'b0;
  logic [3:0]  rate_i = 4'h0;
  logic [7:0]  adc_i = 8'h00;
  logic [12:0] tx_count_o;
  logic [2:0]  split_bits_o;
  logic        tx_no_parity_o, irq_o;
  int          n_errors = 0, check_count = 0, cyc_cnt = 0;

  always #20 clk_i = ~clk_i;

  ctr_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  ctr_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .set_default_i(set_default_i), .rx_start_i(rx_start_i), .coll_i(coll_i),
    .coll_bytes_i(coll_bytes_i), .coll_bit_i(coll_bit_i), .coll_par_i(coll_par_i),
    .wupa_cmd_i(wupa_cmd_i), .card_idle_i(card_idle_i), .rate_valid_i(rate_valid_i),
    .rate_i(rate_i), .adc_done_i(adc_done_i), .adc_i(adc_i), .tx_count_o(tx_count_o),
    .split_bits_o(split_bits_o), .tx_no_parity_o(tx_no_parity_o), .irq_o(irq_o));

  // ==========================================
  // checking and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ==========================================
  // bus and event helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h000000, d}, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, {24'h000000, e});
  endtask

  // pulses are raised by the caller at one edge and dropped here at the next
  task automatic settle();
    @(posedge clk_i);
    {set_default_i, rx_start_i, coll_i, wupa_cmd_i, rate_valid_i, adc_done_i} <= 6'h00;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic coll(input logic [12:0] b, input logic [2:0] bt, input logic p);
    @(posedge clk_i);
    coll_i <= 1'b1;
    coll_bytes_i <= b;
    coll_bit_i <= bt;
    coll_par_i <= p;
    settle();
  endtask

  task automatic rx_new();
    @(posedge clk_i);
    rx_start_i <= 1'b1;
    settle();
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 8'h70; a <= 8'h80; a += 4) rdc(a[7:0], 8'h00);
    rdc(8'hC0, 8'h00);
    wr(8'h74, 8'hAB);
    wr(8'h78, 8'hCD);
    rdc(8'h74, 8'hAB);
    rdc(8'h78, 8'hCD);
    chk({19'h0, tx_count_o}, 32'h0000_1579);
    chk({29'h0, split_bits_o}, 32'h5);
    for (int a = 8'h70; a <= 8'h80; a += 4) wr(a[7:0], 8'hFF);
    for (int a = 8'h70; a <= 8'h80; a += 16) rdc(a[7:0], 8'h00);
    wr(8'h40, 8'h5A);
    rdc(8'h40, 8'h00);
    chk({31'h0, tx_no_parity_o}, 32'h0);
    wr(8'hC8, 8'h01);
    wr(8'hC4, 8'h0F);
    repeat (2) @(posedge clk_i);
    chk({31'h0, tx_no_parity_o}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    @(posedge clk_i);
    wupa_cmd_i <= 1'b1;
    card_idle_i <= 1'b1;
    settle();
    chk({31'h0, irq_o}, 32'h1);
    rdc(8'hC0, 8'h01);
    rdc(8'hC0, 8'h00);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h78, 8'hC8);
    repeat (2) @(posedge clk_i);
    chk({31'h0, tx_no_parity_o}, 32'h0);
    rx_new();
    coll(13'd3, 3'd5, 1'b1);
    rdc(8'h70, 8'h3B);
    rdc(8'hC0, 8'h03);
    coll(13'd1, 3'd2, 1'b0);
    rdc(8'h70, 8'h3B);
    rx_new();
    rdc(8'h70, 8'h00);
    coll(13'd7, 3'd1, 1'b0);
    rdc(8'h70, 8'h00);
    rx_new();
    coll(13'd6, 3'd0, 1'b0);
    rdc(8'h70, 8'h60);
    rdc(8'hC0, 8'h02);
    @(posedge clk_i);
    rate_valid_i <= 1'b1;
    rate_i <= 4'hA;
    adc_done_i <= 1'b1;
    adc_i <= 8'h5C;
    settle();
    rdc(8'h7C, 8'hA0);
    rdc(8'h80, 8'h5C);
    wr(8'hC4, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'hC4, 8'h0C);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'hC0, 8'h0C);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h74, 8'h12);
    @(posedge clk_i);
    set_default_i <= 1'b1;
    settle();
    for (int a = 8'h70; a <= 8'h80; a += 4) rdc(a[7:0], 8'h00);
    rdc(8'hC4, 8'h00);
    chk({19'h0, tx_count_o}, 32'h0);
    print_verdict();
  end
endmodule
